// [rtl/mrb_reading_bank.v]
// Notes on behaviour
// R1: Voltage codes scale so nominal input reads three quarters full scale, C0h.
// R2: Voltage readings refresh on their own at least four times a second.
// R3: Voltage, temperature and tachometer registers ignore bus writes.
// R4: Zone one is first diode, zone two on-die sensor, zone three second diode.
// R5: Temperatures are signed two's complement degrees, minus 127 to plus 127.
// R6: An unused or faulty remote diode loads the sensor-error code 80h.
// R7: Sensor-error reading also sets zone limit flag and diode fault flag.
// R8: Temperature readings refresh on their own at least four times a second.
// R9: Tachometer reading counts fixed timebase periods across one fan revolution.
// R10: One revolution spans two tachometer pulses.
// R11: Each fan reading updates at least once per second.
// R12: Each fan result is sixteen bits split over low and high byte registers.
// R13: Low byte bits one and zero carry accuracy: 11 best, 01 worst, 00 reserved.
// R14: Stopped fan or missing tach signal reports FFFFh.
// R15: Tach measurement keeps running while the fan is disabled or broken.
// R16: Low-byte read freezes high byte; updates resume after the high-byte read.
// R17: During spin-up the reported duty is zero.
// R18: After power-on each output runs full and duty reads FFh.
// R19: Duty follows the automatic algorithm only once the start bit is set.
// R20: Duty writes are ignored unless that fan is in manual test mode.
// R21: Duty is linear, value over 255, zero off and 255 fully on.
// R22: Each reading register changes in one update, never partly.
`include "mrb_defines.vh"

module mrb_reading_bank #(
  parameter REFRESH_CYCLES = `MRB_REFRESH_CYCLES // Cycles between conversion requests.
) (
  input wire sys_clk, // System clock, 20 MHz.
  input wire rst, // Synchronous reset, active high.
  input wire ce, // Clock enable; all state holds while low.
  input wire [7:0] reg_addr, // Register address from the bus engine.
  input wire reg_rd, // Read strobe, one cycle per byte read.
  input wire reg_wr, // Write strobe, one cycle per byte written.
  input wire [7:0] reg_wdata, // Write data byte.
  output reg [7:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  output reg conv_request, // Pulse asking the front end for a conversion round.
  input wire volt_valid, // Pulse: new voltage code present.
  input wire [2:0] volt_sel, // Voltage channel 0..4 in address order.
  input wire [7:0] volt_code, // Scaled voltage code.
  input wire temp_valid, // Pulse: new temperature present.
  input wire [1:0] temp_sel, // Zone 0..2.
  input wire [7:0] temp_code, // Signed whole degrees.
  input wire first_diode_fault, // First remote diode open or shorted.
  input wire second_diode_fault, // Second remote diode open or shorted.
  output reg [2:0] zone_limit_set, // Pulse per zone to the first status register.
  output reg [1:0] diode_fault_set, // Pulse per diode to the second status register.
  input wire [3:0] tach_in, // Tachometer inputs, one per fan.
  input wire start_bit, // Start bit of the control register.
  input wire [2:0] manual_mode, // Manual test mode per PWM output.
  input wire [2:0] spin_up, // Spin-up phase active per PWM output.
  input wire [23:0] auto_duty, // Automatic algorithm duty, fan one in low byte.
  output reg [2:0] pwm_out // PWM outputs.
);

  // Last timebase count, 222 cycles per tick, held at the counter's own width.
  localparam [7:0] TICK_LAST = `MRB_TACH_TICK_LAST;
  localparam integer REFRESH_LAST_FULL = REFRESH_CYCLES - 1;
  localparam [22:0] REFRESH_LAST = REFRESH_LAST_FULL[22:0];

  reg [7:0] volt_reg [0:4];
  reg [7:0] temp_reg [0:2];
  reg [15:0] tach_cnt [0:3];
  reg [15:0] tach_latest [0:3];
  reg [15:0] tach_vis [0:3];
  reg [3:0] tach_prev;
  reg [3:0] tach_phase;
  reg [3:0] tach_frozen;
  reg [7:0] duty [0:2];
  reg [7:0] tick_cnt;
  reg tick;
  reg [22:0] refresh_cnt;
  reg [7:0] pwm_cnt;
  reg [7:0] read_val;
  reg [3:0] rd_low_hit;
  reg [3:0] rd_high_hit;
  reg [2:0] duty_wr_hit;
  reg [7:0] temp_next;
  integer i;

  // Conversion requests pace the front end so every voltage and temperature refreshes at 4 Hz.
  always @(posedge sys_clk) begin
    if (rst) begin
      refresh_cnt <= 23'h000000;
      conv_request <= 1'b0;
    end else if (ce) begin
      conv_request <= 1'b0;
      if (refresh_cnt == REFRESH_LAST) begin
        refresh_cnt <= 23'h000000;
        conv_request <= 1'b1; // R2 R8
      end else begin
        refresh_cnt <= refresh_cnt + 23'h000001;
      end
    end
  end

  // Voltage capture; the code is stored whole, already scaled so nominal reads C0h.
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < 5; i = i + 1) begin
        volt_reg[i] <= `MRB_RST_READING;
      end
    end else if (ce) begin
      if (volt_valid && volt_sel < 3'd5) begin
        volt_reg[volt_sel] <= volt_code; // R1 R2 R22
      end
    end
  end

  // Sensor-error substitution for the remote zones; a measured -128 is clamped so 80h stays unique.
  always @* begin
    temp_next = temp_code;
    if ((temp_sel == `MRB_ZONE_ONE && first_diode_fault) ||
        (temp_sel == `MRB_ZONE_THREE && second_diode_fault)) begin
      temp_next = `MRB_TEMP_SENSOR_ERROR; // R6
    end else if (temp_code == `MRB_TEMP_SENSOR_ERROR) begin
      temp_next = `MRB_TEMP_MIN; // R5
    end
  end

  // Temperature capture by zone, with fault pulses toward the status registers.
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        temp_reg[i] <= `MRB_RST_READING;
      end
      zone_limit_set <= 3'b000;
      diode_fault_set <= 2'b00;
    end else if (ce) begin
      zone_limit_set <= 3'b000;
      diode_fault_set <= 2'b00;
      if (temp_valid && temp_sel <= `MRB_ZONE_THREE) begin
        temp_reg[temp_sel] <= temp_next; // R4 R5 R8 R22
        if (temp_next == `MRB_TEMP_SENSOR_ERROR) begin
          if (temp_sel == `MRB_ZONE_ONE) begin
            zone_limit_set[0] <= 1'b1; // R7
            diode_fault_set[0] <= 1'b1; // R7
          end
          if (temp_sel == `MRB_ZONE_THREE) begin
            zone_limit_set[2] <= 1'b1; // R7
            diode_fault_set[1] <= 1'b1; // R7
          end
        end
      end
    end
  end

  // Tachometer timebase: one tick per 222 cycles, an 11.1 us period at 20 MHz.
  always @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (tick_cnt == TICK_LAST) begin
        tick_cnt <= 8'h00;
        tick <= 1'b1; // R9
      end else begin
        tick_cnt <= tick_cnt + 8'h01;
      end
    end
  end

  // Bus strobes decoded once; the read side effects drive the tach latch.
  always @* begin
    rd_low_hit = 4'b0000;
    rd_high_hit = 4'b0000;
    duty_wr_hit = 3'b000;
    for (i = 0; i < 4; i = i + 1) begin
      rd_low_hit[i] = reg_rd && (reg_addr == `MRB_ADDR_FAN_ONE_LOW + 2 * i);
      rd_high_hit[i] = reg_rd && (reg_addr == `MRB_ADDR_FAN_ONE_HIGH + 2 * i);
    end
    for (i = 0; i < 3; i = i + 1) begin
      duty_wr_hit[i] = reg_wr && (reg_addr == `MRB_ADDR_FAN_ONE_DUTY + i);
    end
  end

  // Period measurement runs regardless of fan drive state, so a dead fan still reads FFFFh.
  always @(posedge sys_clk) begin
    if (rst) begin
      tach_prev <= 4'h0;
      tach_phase <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        tach_cnt[i] <= `MRB_TACH_ZERO;
        tach_latest[i] <= `MRB_TACH_STOPPED;
      end
    end else if (ce) begin
      tach_prev <= tach_in; // R15
      for (i = 0; i < 4; i = i + 1) begin
        if (tach_in[i] && !tach_prev[i]) begin
          tach_phase[i] <= ~tach_phase[i];
          if (tach_phase[i]) begin
            // Second pulse closes one revolution.
            tach_cnt[i] <= `MRB_TACH_ZERO; // R10
            if (tach_cnt[i] == `MRB_TACH_STOPPED) begin
              tach_latest[i] <= `MRB_TACH_STOPPED; // R14
            end else if (tach_cnt[i] >= `MRB_TACH_FINE_MIN) begin
              tach_latest[i] <= {tach_cnt[i][15:2], `MRB_ACC_MOST}; // R9 R13
            end else begin
              tach_latest[i] <= {tach_cnt[i][15:2], `MRB_ACC_LEAST}; // R13
            end
          end
        end else if (tick && tach_cnt[i] != `MRB_TACH_STOPPED) begin
          tach_cnt[i] <= tach_cnt[i] + 16'h0001; // R9
        end else if (tach_cnt[i] == `MRB_TACH_STOPPED) begin
          // Saturation takes about 0.73 s, well inside the one-second refresh bound.
          tach_latest[i] <= `MRB_TACH_STOPPED; // R11 R14
        end
      end
    end
  end

  // Visible tach pairs copy whole words only while unlatched, so the two bytes always match.
  always @(posedge sys_clk) begin
    if (rst) begin
      tach_frozen <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        tach_vis[i] <= `MRB_TACH_STOPPED;
      end
    end else if (ce) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (rd_low_hit[i]) begin
          tach_frozen[i] <= 1'b1; // R16
        end else if (rd_high_hit[i]) begin
          tach_frozen[i] <= 1'b0; // R16
        end
        if (!tach_frozen[i] && !rd_low_hit[i]) begin
          tach_vis[i] <= tach_latest[i]; // R11 R12 R22
        end
      end
    end
  end

  // Duty registers: full at reset, automatic after start, writable only in manual mode.
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        duty[i] <= `MRB_RST_DUTY; // R18
      end
    end else if (ce) begin
      for (i = 0; i < 3; i = i + 1) begin
        if (manual_mode[i]) begin
          if (duty_wr_hit[i]) begin
            duty[i] <= reg_wdata; // R20
          end
        end else if (start_bit) begin
          duty[i] <= auto_duty[8 * i +: 8]; // R19
        end
      end
    end
  end

  // PWM counter spans 255 steps so FFh is never low and 00h is never high.
  always @(posedge sys_clk) begin
    if (rst) begin
      pwm_cnt <= 8'h00;
      pwm_out <= 3'b111; // R18
    end else if (ce) begin
      if (pwm_cnt == `MRB_PWM_TOP) begin
        pwm_cnt <= 8'h00;
      end else begin
        pwm_cnt <= pwm_cnt + 8'h01;
      end
      for (i = 0; i < 3; i = i + 1) begin
        pwm_out[i] <= (pwm_cnt < duty[i]); // R21
      end
    end
  end

  // Read multiplexer; reading registers have no write path at all, so writes fall away.
  always @* begin
    read_val = `MRB_UNMAPPED_READ;
    case (reg_addr)
      `MRB_ADDR_SUPPLY_2V5: read_val = volt_reg[0];
      `MRB_ADDR_CPU_CORE_SUPPLY: read_val = volt_reg[1];
      `MRB_ADDR_SUPPLY_3V3: read_val = volt_reg[2];
      `MRB_ADDR_SUPPLY_5V: read_val = volt_reg[3];
      `MRB_ADDR_SUPPLY_12V: read_val = volt_reg[4];
      `MRB_ADDR_ZONE_ONE_TEMP: read_val = temp_reg[0]; // R4
      `MRB_ADDR_ZONE_TWO_TEMP: read_val = temp_reg[1]; // R4
      `MRB_ADDR_ZONE_THREE_TEMP: read_val = temp_reg[2]; // R4
      `MRB_ADDR_FAN_ONE_LOW: read_val = tach_vis[0][7:0]; // R12
      `MRB_ADDR_FAN_ONE_HIGH: read_val = tach_vis[0][15:8]; // R12
      `MRB_ADDR_FAN_TWO_LOW: read_val = tach_vis[1][7:0];
      `MRB_ADDR_FAN_TWO_HIGH: read_val = tach_vis[1][15:8];
      `MRB_ADDR_FAN_THREE_LOW: read_val = tach_vis[2][7:0];
      `MRB_ADDR_FAN_THREE_HIGH: read_val = tach_vis[2][15:8];
      `MRB_ADDR_FAN_FOUR_LOW: read_val = tach_vis[3][7:0];
      `MRB_ADDR_FAN_FOUR_HIGH: read_val = tach_vis[3][15:8];
      `MRB_ADDR_FAN_ONE_DUTY: read_val = spin_up[0] ? `MRB_DUTY_OFF : duty[0]; // R17
      `MRB_ADDR_FAN_TWO_DUTY: read_val = spin_up[1] ? `MRB_DUTY_OFF : duty[1]; // R17
      `MRB_ADDR_FAN_THREE_DUTY: read_val = spin_up[2] ? `MRB_DUTY_OFF : duty[2]; // R17
      default: read_val = `MRB_UNMAPPED_READ; // R3
    endcase
  end

  // Read data is registered on the strobe and held until the next read.
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= `MRB_UNMAPPED_READ;
    end else if (ce && reg_rd) begin
      reg_rdata <= read_val;
    end
  end

endmodule // mrb_reading_bank

// [rtl/mrb_defines.vh]
`ifndef MRB_DEFINES_VH
`define MRB_DEFINES_VH

// Register addresses on the management bus.
`define MRB_ADDR_SUPPLY_2V5 8'h20
`define MRB_ADDR_CPU_CORE_SUPPLY 8'h21
`define MRB_ADDR_SUPPLY_3V3 8'h22
`define MRB_ADDR_SUPPLY_5V 8'h23
`define MRB_ADDR_SUPPLY_12V 8'h24
`define MRB_ADDR_ZONE_ONE_TEMP 8'h25
`define MRB_ADDR_ZONE_TWO_TEMP 8'h26
`define MRB_ADDR_ZONE_THREE_TEMP 8'h27
`define MRB_ADDR_FAN_ONE_LOW 8'h28
`define MRB_ADDR_FAN_ONE_HIGH 8'h29
`define MRB_ADDR_FAN_TWO_LOW 8'h2A
`define MRB_ADDR_FAN_TWO_HIGH 8'h2B
`define MRB_ADDR_FAN_THREE_LOW 8'h2C
`define MRB_ADDR_FAN_THREE_HIGH 8'h2D
`define MRB_ADDR_FAN_FOUR_LOW 8'h2E
`define MRB_ADDR_FAN_FOUR_HIGH 8'h2F
`define MRB_ADDR_FAN_ONE_DUTY 8'h30
`define MRB_ADDR_FAN_TWO_DUTY 8'h31
`define MRB_ADDR_FAN_THREE_DUTY 8'h32

// Reset values and special codes.
`define MRB_RST_READING 8'h00
`define MRB_RST_DUTY 8'hFF
`define MRB_DUTY_OFF 8'h00
`define MRB_UNMAPPED_READ 8'h00
`define MRB_TEMP_SENSOR_ERROR 8'h80
`define MRB_TEMP_MIN 8'h81
`define MRB_TACH_STOPPED 16'hFFFF
`define MRB_TACH_ZERO 16'h0000
`define MRB_TACH_FINE_MIN 16'h0100
`define MRB_ACC_MOST 2'b11
`define MRB_ACC_LEAST 2'b01
`define MRB_PWM_TOP 8'hFE

// Zone selectors on the temperature update port.
`define MRB_ZONE_ONE 2'd0
`define MRB_ZONE_TWO 2'd1
`define MRB_ZONE_THREE 2'd2

// Timing.
`define MRB_CLK_HZ 20000000
`define MRB_TACH_TICK_NS 11111
`define MRB_TACH_TICK_CYCLES ((`MRB_TACH_TICK_NS * (`MRB_CLK_HZ / 1000000)) / 1000)
`define MRB_TACH_TICK_LAST 8'hDD
`define MRB_REFRESH_HZ 4
`define MRB_REFRESH_CYCLES (`MRB_CLK_HZ / `MRB_REFRESH_HZ)

`endif

// [bench/mrb_reading_bank_props.sv]
module mrb_reading_bank_props #(
  parameter int REFRESH_CYCLES = 50 // Cycles between requests.
) (
  input wire sys_clk, // Clock.
  input wire rst, // Reset.
  input wire [7:0] reg_addr, // Address.
  input wire reg_rd, // Read strobe.
  input wire [7:0] reg_rdata, // Read data.
  input wire conv_request, // Request pulse.
  input wire temp_valid, // New temperature.
  input wire [1:0] temp_sel, // Zone.
  input wire first_diode_fault, // First diode fault.
  input wire second_diode_fault, // Second diode fault.
  input wire [2:0] zone_limit_set, // Zone flags.
  input wire [1:0] diode_fault_set, // Diode flags.
  input wire [2:0] spin_up, // Spin-up phase.
  input wire [2:0] pwm_out // PWM outputs.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A faulty diode sample is the first step; the flag pulses are the second.
  sequence s_err_one; temp_valid && temp_sel == 2'd0 && first_diode_fault; endsequence
  sequence s_err_three; temp_valid && temp_sel == 2'd2 && second_diode_fault; endsequence
  property p_err_one; s_err_one |=> zone_limit_set[0] && diode_fault_set[0]; endproperty
  property p_err_three; s_err_three |=> zone_limit_set[2] && diode_fault_set[1]; endproperty
  property p_flag_cause; diode_fault_set[1] |-> $past(second_diode_fault) && $past(temp_valid);
  endproperty
  property p_zone_two; zone_limit_set[1] == 1'b0; endproperty
  property p_conv_period; conv_request |-> ##50 conv_request; endproperty
  property p_conv_pulse; conv_request |=> !conv_request; endproperty
  property p_spin_zero; reg_rd && reg_addr == 8'h31 && spin_up[1] |=> reg_rdata == 8'h00;
  endproperty
  property p_stands; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_pwm_reset; $fell(rst) |-> (pwm_out == 3'b111) [*8]; endproperty
  // Holds only while the bench keeps the third tach input quiet.
  property p_tach_idle; reg_rd && reg_addr == 8'h2D |=> reg_rdata == 8'hFF; endproperty
  a_err_one: assert property (p_err_one)
    else $error("Zone one error flags missing.");
  a_err_three: assert property (p_err_three)
    else $error("Zone three error flags missing.");
  a_flag_cause: assert property (p_flag_cause)
    else $error("Diode flag without a faulty sample.");
  a_zone_two: assert property (p_zone_two)
    else $error("Zone two flag raised.");
  a_conv_period: assert property (p_conv_period)
    else $error("Request period wrong.");
  a_conv_pulse: assert property (p_conv_pulse)
    else $error("Request longer than one cycle.");
  a_spin_zero: assert property (p_spin_zero)
    else $error("Duty not zero during spin-up.");
  a_stands: assert property (p_stands)
    else $error("Read data changed without a read.");
  a_pwm_reset: assert property (p_pwm_reset)
    else $error("Outputs not full after reset.");
  a_tach_idle: assert property (p_tach_idle)
    else $error("Idle fan high byte not all ones.");
endmodule // mrb_reading_bank_props

// [bench/mrb_host_model.sv]
module mrb_host_model (
  input wire sys_clk, // Clock.
  output logic [7:0] reg_addr, // Address.
  output logic reg_rd, // Read strobe.
  output logic reg_wr, // Write strobe.
  output logic [7:0] reg_wdata // Write data.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle lines show the inverse of the last value, so a stale address never looks live.
  initial begin
    reg_addr = 8'hFF;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One byte per strobe, held over exactly one taking edge.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule // mrb_host_model

// [bench/tb_mrb_reading_bank.sv]
module tb_mrb_reading_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_rd, reg_wr, conv_request, pend = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, volt_code = 8'h00, temp_code = 8'h00, v, t;
  logic volt_valid = 1'b0, temp_valid = 1'b0, first_diode_fault = 1'b0;
  logic second_diode_fault = 1'b0, start_bit = 1'b0;
  logic [2:0] volt_sel = 3'h0, zone_limit_set, pwm_out, manual_mode = 3'h0, spin_up = 3'h0;
  logic [1:0] temp_sel = 2'h0, diode_fault_set;
  logic [3:0] tach_in = 4'h0;
  logic [23:0] auto_duty = 24'h000000, a;
  logic [7:0] exp_q[$];
  int fail_count = 0, num_checks = 0;
  mrb_reading_bank #(.REFRESH_CYCLES(50)) u_mrb_reading_bank (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_request(conv_request), .volt_valid(volt_valid),
    .volt_sel(volt_sel), .volt_code(volt_code), .temp_valid(temp_valid), .temp_sel(temp_sel),
    .temp_code(temp_code), .first_diode_fault(first_diode_fault),
    .second_diode_fault(second_diode_fault), .zone_limit_set(zone_limit_set),
    .diode_fault_set(diode_fault_set), .tach_in(tach_in), .start_bit(start_bit),
    .manual_mode(manual_mode), .spin_up(spin_up), .auto_duty(auto_duty), .pwm_out(pwm_out));
  mrb_host_model u_mrb_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  // Clock at 20 MHz.
  initial forever #25 sys_clk = ~sys_clk;
  // Fan one spins: a rising edge every 2000 cycles, so one revolution is about 18 ticks.
  initial forever begin
    repeat (1000) @(posedge sys_clk);
    tach_in[0] <= ~tach_in[0];
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic expect_rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    u_mrb_host_model.rd(ad);
  endtask
  task automatic put_temp(input logic [1:0] s, input logic [7:0] c, input logic f1, f2);
    @(posedge sys_clk);
    temp_valid <= 1'b1;
    temp_sel <= s;
    temp_code <= c;
    first_diode_fault <= f1;
    second_diode_fault <= f2;
    @(posedge sys_clk);
    temp_valid <= 1'b0;
  endtask
  // Read data is settled one edge after the taking edge, so compare it then.
  always @(posedge sys_clk) begin
    if (pend === 1'b1) check_byte(reg_rdata, exp_q.pop_front());
    pend <= reg_rd;
  end
  // Watchdog sized well above the roughly 14100 cycles the sequence needs.
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(69015));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) expect_rd(8'h30 + 8'(i), 8'hFF);
    expect_rd(8'h40, 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      @(posedge sys_clk);
      volt_valid <= 1'b1;
      volt_sel <= 3'(i);
      volt_code <= v;
      @(posedge sys_clk);
      volt_valid <= 1'b0;
      u_mrb_host_model.wr(8'h20 + 8'(i), ~v);
      expect_rd(8'h20 + 8'(i), v);
    end
    t = 8'($urandom_range(254)) + 8'h81;
    put_temp(2'd0, t, 1'b1, 1'b0);
    expect_rd(8'h25, 8'h80);
    put_temp(2'd1, 8'h80, 1'b1, 1'b1);
    expect_rd(8'h26, 8'h81);
    put_temp(2'd2, t, 1'b0, 1'b1);
    expect_rd(8'h27, 8'h80);
    put_temp(2'd2, t, 1'b0, 1'b0);
    u_mrb_host_model.wr(8'h27, ~t);
    expect_rd(8'h27, t);
    u_mrb_host_model.wr(8'h31, 8'h00);
    expect_rd(8'h31, 8'hFF);
    manual_mode <= 3'b001;
    v = 8'($urandom);
    u_mrb_host_model.wr(8'h30, v);
    expect_rd(8'h30, v);
    spin_up <= 3'b010;
    expect_rd(8'h31, 8'h00);
    spin_up <= 3'b000;
    a = 24'($urandom);
    auto_duty <= a;
    start_bit <= 1'b1;
    expect_rd(8'h32, a[23:16]);
    expect_rd(8'h30, v);
    repeat (14000) @(posedge sys_clk);
    expect_rd(8'h28, 8'h11);
    expect_rd(8'h29, 8'h00);
    expect_rd(8'h2C, 8'hFF);
    expect_rd(8'h2D, 8'hFF);
    repeat (3) @(posedge sys_clk);
    final_report();
  end
endmodule // tb_mrb_reading_bank
bind mrb_reading_bank mrb_reading_bank_props #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_request(conv_request), .temp_valid(temp_valid), .temp_sel(temp_sel),
  .first_diode_fault(first_diode_fault), .second_diode_fault(second_diode_fault),
  .zone_limit_set(zone_limit_set), .diode_fault_set(diode_fault_set), .spin_up(spin_up),
  .pwm_out(pwm_out));
